// *** pkg/mma_pkg.sv ***
package mma_pkg;
    // Bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    // Register byte offsets.
    localparam logic [7:0] ADDR_REG_OFF = 8'h14;
    localparam logic [7:0] DATA_REG_OFF = 8'h18;
    localparam logic [7:0] FLOW_REG_OFF = 8'h1c;
    // Field positions.
    localparam int PHY_LSB = 11;
    localparam int REGAD_LSB = 6;
    localparam int DIR_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int PT_LSB = 16;
    localparam int FCE_BIT = 1;
    localparam int FCB_BIT = 0;
    // Reset values.
    localparam logic [4:0] PHY_RST = 5'h0b;
    localparam logic [4:0] REGAD_RST = 5'h0b;
    localparam logic [15:0] PT_RST = 16'h0050;
    localparam logic FCE_RST = 1'b1;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Management frame layout, in link clock cycles.
    localparam logic [1:0] ST_CODE = 2'h1;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] TA_WR = 2'h2;
    localparam logic [31:0] PREAMBLE = 32'hffffffff;
    localparam logic [6:0] TA_CYC = 7'h2e;
    localparam logic [6:0] CAPT_CYC = 7'h32;
    localparam logic [6:0] FRAME_CYC = 7'h40;
    localparam logic [6:0] LAST_CYC = 7'h41;
    // Pause slot timing.
    localparam int SYS_CLK_NS = 4;
    localparam int SLOT_BIT_TIMES = 512;
    localparam int LINE_BIT_NS = 10;
    localparam int SLOT_NS = SLOT_BIT_TIMES * LINE_BIT_NS;
    localparam int SLOT_CYC = SLOT_NS / SYS_CLK_NS;
    typedef enum logic [0:0] {
        MMA_LK_IDLE = 1'b0,
        MMA_LK_FRAME = 1'b1
    } mma_lk_state_t;
endpackage

// *** pkg/mma_link_if.sv ***
`timescale 1ns/100ps
interface mma_link_if;
    logic req_tgl;
    logic wr_dir;
    logic [4:0] phy;
    logic [4:0] regad;
    logic [15:0] wdata;
    logic done_tgl;
    logic [15:0] rdata;
    modport sys (
        output req_tgl, wr_dir, phy, regad, wdata,
        input done_tgl, rdata
    );
    modport link (
        input req_tgl, wr_dir, phy, regad, wdata,
        output done_tgl, rdata
    );
endinterface

// *** hdl/mma_mdio_link.sv ***
`timescale 1ns/100ps
module mma_mdio_link (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic rstn,
    // Command crossing
    mma_link_if.link lk,
    // Management data pin
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe
);
    import mma_pkg::*;

    logic [2:0] req_sync_r;
    logic [1:0] mdio_sync_r;
    mma_lk_state_t state_r, state_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic [63:0] sh_r, sh_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic dir_r, dir_nxt;
    logic done_r, done_nxt;

    // The command words are stable while the request toggle is in flight.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        dir_nxt = dir_r;
        done_nxt = done_r;
        case (state_r)
            MMA_LK_IDLE: begin
                if (req_sync_r[1] != req_sync_r[2]) begin
                    state_nxt = MMA_LK_FRAME;
                    cnt_nxt = 7'h00;
                    dir_nxt = lk.wr_dir;
                    sh_nxt = {PREAMBLE, ST_CODE, lk.wr_dir ? OP_WR : OP_RD,
                              lk.phy, lk.regad, TA_WR, lk.wdata};
                end
            end
            MMA_LK_FRAME: begin
                cnt_nxt = cnt_r + 7'h01;
                sh_nxt = {sh_r[62:0], 1'b1};
                // The pin synchroniser delays read data by two cycles.
                if (!dir_r && cnt_r >= CAPT_CYC) begin
                    rd_nxt = {rd_r[14:0], mdio_sync_r[1]};
                end
                if (cnt_r == LAST_CYC) begin
                    state_nxt = MMA_LK_IDLE;
                    done_nxt = ~done_r;
                end
            end
            default: begin
                state_nxt = MMA_LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            req_sync_r <= 3'h0;
            mdio_sync_r <= 2'h0;
            state_r <= MMA_LK_IDLE;
            cnt_r <= 7'h00;
            sh_r <= 64'h0;
            rd_r <= 16'h0000;
            dir_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            req_sync_r <= {req_sync_r[1:0], lk.req_tgl};
            mdio_sync_r <= {mdio_sync_r[0], mdio_i};
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            dir_r <= dir_nxt;
            done_r <= done_nxt;
        end
    end

    // Reads release the line at turnaround so the PHY can answer.
    assign mdio_o = sh_r[63];
    assign mdio_oe = (state_r == MMA_LK_FRAME) && (cnt_r < (dir_r ? FRAME_CYC : TA_CYC));
    assign lk.done_tgl = done_r;
    assign lk.rdata = rd_r;
endmodule

// *** hdl/mma_mgmt_top.sv ***
`timescale 1ns/100ps

// Overview of operation
// - Address register bits 15 to 11 choose one of 32 PHY addresses.
// - Address register bits 10 to 6 choose the register inside that PHY.
// - Direction bit one runs a management write of the data register.
// - Direction bit zero runs a read and stores the answer in the data register.
// - Busy flag is one while a transaction runs, zero once it ends.
// - Data register bits 15 to 0 carry write data and read results.
// - Pause time bits 31 to 16 go into transmitted pause frames.
// - Software sets pause busy to send a pause frame; cleared when sent.
// - With flow control enabled, received pause frames hold off the transmitter.
module mma_mgmt_top #(
    parameter int SLOT_CYCLES = mma_pkg::SLOT_CYC
) (
    // System clock and reset
    input wire logic clock,
    input wire logic rstn,
    // AXI4-Lite write address
    input wire logic [mma_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [mma_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [mma_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [mma_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [mma_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Management link
    input wire logic mdc_clk,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // Pause frame transmit request
    output logic pause_tx_req,
    output logic [15:0] pause_tx_time,
    input wire logic pause_tx_done,
    // Received pause and transmit hold-off
    input wire logic rx_pause_valid,
    input wire logic [15:0] rx_pause_quanta,
    output logic tx_pause_hold
);
    import mma_pkg::*;

    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic same_word(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] off
    );
        return addr[ADDR_W-1:2] == off[7:2];
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        return same_word(addr, ADDR_REG_OFF) || same_word(addr, DATA_REG_OFF)
            || same_word(addr, FLOW_REG_OFF);
    endfunction

    // Write channel state.
    logic aw_have_r, aw_have_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic w_have_r, w_have_nxt;
    logic [DATA_W-1:0] w_data_r, w_data_nxt;
    logic [STRB_W-1:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic wr_go;

    // Read channel state.
    logic rvalid_r, rvalid_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    // Management and flow control registers.
    logic [4:0] phy_r, phy_nxt;
    logic [4:0] regad_r, regad_nxt;
    logic dir_r, dir_nxt;
    logic busy_r, busy_nxt;
    logic [15:0] data_r, data_nxt;
    logic [15:0] pt_r, pt_nxt;
    logic fce_r, fce_nxt;
    logic fcb_r, fcb_nxt;
    logic req_tgl_r, req_tgl_nxt;
    logic [2:0] done_sync_r;
    logic link_done;

    // Pause hold-off counters.
    logic [15:0] quanta_r, quanta_nxt;
    logic [15:0] slot_r, slot_nxt;

    logic [DATA_W-1:0] addr_img;
    logic [DATA_W-1:0] data_img;
    logic [DATA_W-1:0] flow_img;
    logic [DATA_W-1:0] wr_merged;

    mma_link_if lk_if ();

    assign addr_img = {16'h0000, phy_r, regad_r, 4'h0, dir_r, busy_r};
    assign data_img = {16'h0000, data_r};
    assign flow_img = {pt_r, 14'h0000, fce_r, fcb_r};

    assign wr_go = aw_have_r && w_have_r && !bvalid_r;
    assign link_done = done_sync_r[1] != done_sync_r[2];

    // Address and data are taken independently and committed together.
    always_comb begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt = w_have_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_go) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = addr_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r <= w_have_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // Reads answer one cycle after the address is taken.
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            if (same_word(s_axi_araddr, ADDR_REG_OFF)) begin
                rdata_nxt = addr_img;
            end else if (same_word(s_axi_araddr, DATA_REG_OFF)) begin
                rdata_nxt = data_img;
            end else if (same_word(s_axi_araddr, FLOW_REG_OFF)) begin
                rdata_nxt = flow_img;
            end else begin
                rdata_nxt = '0;
                rresp_nxt = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Command fields freeze while busy so the link sees stable words.
    always_comb begin
        phy_nxt = phy_r;
        regad_nxt = regad_r;
        dir_nxt = dir_r;
        busy_nxt = busy_r;
        data_nxt = data_r;
        pt_nxt = pt_r;
        fce_nxt = fce_r;
        fcb_nxt = fcb_r;
        req_tgl_nxt = req_tgl_r;
        wr_merged = '0;
        if (link_done) begin
            busy_nxt = 1'b0;
            if (!dir_r) begin
                data_nxt = lk_if.rdata;
            end
        end
        if (pause_tx_done) begin
            fcb_nxt = 1'b0;
        end
        if (wr_go && same_word(aw_addr_r, ADDR_REG_OFF) && !busy_r) begin
            wr_merged = merge_bytes(addr_img, w_data_r, w_strb_r);
            phy_nxt = wr_merged[PHY_LSB +: 5];
            regad_nxt = wr_merged[REGAD_LSB +: 5];
            dir_nxt = wr_merged[DIR_BIT];
            if (wr_merged[BUSY_BIT]) begin
                busy_nxt = 1'b1;
                req_tgl_nxt = ~req_tgl_r;
            end
        end
        if (wr_go && same_word(aw_addr_r, DATA_REG_OFF) && !busy_r) begin
            wr_merged = merge_bytes(data_img, w_data_r, w_strb_r);
            data_nxt = wr_merged[15:0];
        end
        if (wr_go && same_word(aw_addr_r, FLOW_REG_OFF)) begin
            wr_merged = merge_bytes(flow_img, w_data_r, w_strb_r);
            pt_nxt = wr_merged[PT_LSB +: 16];
            fce_nxt = wr_merged[FCE_BIT];
            // A new request is accepted only once the previous one is sent.
            if (wr_merged[FCB_BIT] && !fcb_r) begin
                fcb_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phy_r <= PHY_RST;
            regad_r <= REGAD_RST;
            dir_r <= 1'b0;
            busy_r <= 1'b0;
            data_r <= 16'h0000;
            pt_r <= PT_RST;
            fce_r <= FCE_RST;
            fcb_r <= 1'b0;
            req_tgl_r <= 1'b0;
            done_sync_r <= 3'h0;
        end else begin
            phy_r <= phy_nxt;
            regad_r <= regad_nxt;
            dir_r <= dir_nxt;
            busy_r <= busy_nxt;
            data_r <= data_nxt;
            pt_r <= pt_nxt;
            fce_r <= fce_nxt;
            fcb_r <= fcb_nxt;
            req_tgl_r <= req_tgl_nxt;
            done_sync_r <= {done_sync_r[1:0], lk_if.done_tgl};
        end
    end

    // A new pause frame restarts the count; a zero quanta ends the hold.
    always_comb begin
        quanta_nxt = quanta_r;
        slot_nxt = slot_r;
        if (rx_pause_valid && fce_r) begin
            quanta_nxt = rx_pause_quanta;
            slot_nxt = 16'h0000;
        end else if (quanta_r != 16'h0000) begin
            if (slot_r == 16'(SLOT_CYCLES - 1)) begin
                slot_nxt = 16'h0000;
                quanta_nxt = quanta_r - 16'h0001;
            end else begin
                slot_nxt = slot_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            quanta_r <= 16'h0000;
            slot_r <= 16'h0000;
        end else begin
            quanta_r <= quanta_nxt;
            slot_r <= slot_nxt;
        end
    end

    assign lk_if.req_tgl = req_tgl_r;
    assign lk_if.wr_dir = dir_r;
    assign lk_if.phy = phy_r;
    assign lk_if.regad = regad_r;
    assign lk_if.wdata = data_r;

    // The link engine runs on the management clock; only the toggles are synchronised, the command and read words cross held stable.
    mma_mdio_link u_link (
        .link_clk(mdc_clk),
        .rstn(rstn),
        .lk(lk_if.link),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe(mdio_oe)
    );

    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready = !w_have_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign pause_tx_req = fcb_r;
    assign pause_tx_time = pt_r;
    // Clearing the enable drops the hold at once.
    assign tx_pause_hold = fce_r && (quanta_r != 16'h0000);
endmodule

// *** tb/mma_mgmt_props.sv ***
`timescale 1ns/100ps
module mma_mgmt_props (
    // System side
    input wire logic clock,
    input wire logic rstn,
    input wire logic s_axi_bvalid,
    // Management link
    input wire logic mdc_clk,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    // Pause paths
    input wire logic pause_tx_req,
    input wire logic [15:0] pause_tx_time,
    input wire logic pause_tx_done,
    input wire logic rx_pause_valid,
    input wire logic [15:0] rx_pause_quanta,
    input wire logic tx_pause_hold
);
    logic [6:0] oe_run_r;
    logic [6:0] oe_run_nxt;

    // Length of the driven span, so turnaround timing can be judged.
    always_comb begin
        oe_run_nxt = mdio_oe ? oe_run_r + 7'h01 : 7'h00;
    end
    always_ff @(posedge mdc_clk or negedge rstn) begin
        if (!rstn) oe_run_r <= 7'h00;
        else oe_run_r <= oe_run_nxt;
    end

    sequence preamble_s;
        (mdio_oe && mdio_o) [*8];
    endsequence
    sequence start_s;
        !mdio_o ##1 mdio_o;
    endsequence

    a_frame_preamble: assert property (@(posedge mdc_clk) disable iff (!rstn)
        $rose(mdio_oe) |-> preamble_s) else $error("No preamble at frame start");
    a_start_code: assert property (@(posedge mdc_clk) disable iff (!rstn)
        mdio_oe && oe_run_r == 7'h20 |-> start_s) else $error("Bad start code");
    a_drive_span: assert property (@(posedge mdc_clk) disable iff (!rstn)
        $fell(mdio_oe) |-> oe_run_r == 7'h40 || oe_run_r == 7'h2e)
        else $error("Wrong driven span length");
    a_pause_time: assert property (@(posedge clock) disable iff (!rstn)
        $changed(pause_tx_time) |-> $rose(s_axi_bvalid)) else $error("Pause time moved alone");
    a_pause_start: assert property (@(posedge clock) disable iff (!rstn)
        $rose(pause_tx_req) |-> $rose(s_axi_bvalid)) else $error("Pause request without write");
    a_pause_end: assert property (@(posedge clock) disable iff (!rstn)
        pause_tx_req && pause_tx_done |-> ##[1:2] !pause_tx_req)
        else $error("Pause request not cleared");
    a_pause_cause: assert property (@(posedge clock) disable iff (!rstn)
        $fell(pause_tx_req) |-> $past(pause_tx_done) || $past(pause_tx_done, 2))
        else $error("Pause request cleared early");
    a_hold_cause: assert property (@(posedge clock) disable iff (!rstn)
        $rose(tx_pause_hold) |-> $past(rx_pause_valid) || $past(rx_pause_valid, 2))
        else $error("Hold without received pause");
    a_hold_zero: assert property (@(posedge clock) disable iff (!rstn)
        rx_pause_valid && rx_pause_quanta == 16'h0000 |-> ##[1:2] !tx_pause_hold)
        else $error("Zero pause did not end hold");
endmodule

bind mma_mgmt_top mma_mgmt_props mma_mgmt_props_i (.clock(clock), .rstn(rstn),
    .s_axi_bvalid(s_axi_bvalid), .mdc_clk(mdc_clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .pause_tx_req(pause_tx_req), .pause_tx_time(pause_tx_time),
    .pause_tx_done(pause_tx_done), .rx_pause_valid(rx_pause_valid),
    .rx_pause_quanta(rx_pause_quanta), .tx_pause_hold(tx_pause_hold));

// *** tb/mma_phy_model.sv ***
`timescale 1ns/100ps
module mma_phy_model (
    // Link clock and wire
    input wire logic mdc_clk,
    input wire logic dev_oe,
    input wire logic mdio_line,
    // Drive toward the wire
    output logic phy_o,
    output logic phy_oe,
    // Last frame seen
    output logic [15:0] hdr,
    output logic [15:0] wdat,
    output logic [5:0] ones
);
    import mma_pkg::*;
    logic act;
    logic [6:0] pos;
    logic [15:0] rd;
    logic [15:0] regs [32];

    initial begin
        act = 1'b0;
        pos = 7'h00;
        phy_o = 1'b1;
        phy_oe = 1'b0;
        hdr = 16'h0000;
        wdat = 16'h0000;
        ones = 6'h00;
        rd = 16'h0000;
        for (int i = 0; i < 32; i++) regs[i] = 16'h5a00 | 16'(i);
    end

    // Bits are sampled on the rising link clock and answers launched just after it.
    always @(posedge mdc_clk) begin
        if (!act && dev_oe) begin
            act <= 1'b1;
            pos <= 7'h01;
            ones <= {5'h00, mdio_line};
        end else if (act) begin
            pos <= pos + 7'h01;
            if (pos < 7'h20) ones <= ones + {5'h00, mdio_line};
            if (pos >= 7'h20 && pos < 7'h30) hdr <= {hdr[14:0], mdio_line};
            if (pos >= 7'h30) wdat <= {wdat[14:0], mdio_line};
            if (pos == 7'h2e) begin
                rd <= regs[hdr[4:0]];
                phy_oe <= (hdr[11:10] == OP_RD);
                phy_o <= 1'b0;
            end
            if (pos >= 7'h2f && pos < 7'h3f) phy_o <= rd[4'(7'h3e - pos)];
            if (pos == 7'h3f) begin
                act <= 1'b0;
                phy_oe <= 1'b0;
                phy_o <= 1'b1;
                if (hdr[13:12] == OP_WR) regs[hdr[6:2]] <= {wdat[14:0], mdio_line};
            end
        end
    end
endmodule

// *** tb/mac_mdio_management_access_tb.sv ***
`timescale 1ns/100ps
module mac_mdio_management_access_tb;
    import mma_pkg::*;
    logic clock, rstn, mdc_clk, mdio_o, mdio_oe, mdio_line, phy_o, phy_oe;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic pause_tx_req, pause_tx_done, rx_pause_valid, tx_pause_hold;
    logic [15:0] pause_tx_time, rx_pause_quanta, hdr, wdat;
    logic [5:0] ones;
    int n_fail = 0;
    int checks_done = 0;

    mma_mgmt_top #(.SLOT_CYCLES(4)) mma_mgmt_top_i (.clock, .rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mdc_clk, .mdio_i(mdio_line), .mdio_o, .mdio_oe, .pause_tx_req,
        .pause_tx_time, .pause_tx_done, .rx_pause_valid, .rx_pause_quanta, .tx_pause_hold);
    mma_phy_model mma_phy_model_i (.mdc_clk, .dev_oe(mdio_oe), .mdio_line, .phy_o,
        .phy_oe, .hdr, .wdat, .ones);
    // A released line floats to the pull-up level.
    assign mdio_line = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        mdc_clk = 1'b0;
        #3;
        forever #16 mdc_clk = ~mdc_clk;
    end

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is looked at mid-cycle so the handshake edge is known without a race.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clock);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clock);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_idle;
        logic [31:0] d;
        logic [1:0] r;
        d = 32'h1;
        while (d[BUSY_BIT] !== 1'b0) axi_rd(ADDR_REG_OFF, d, r);
    endtask

    task automatic rx_pause(input logic [15:0] q);
        @(posedge clock);
        rx_pause_valid <= 1'b1;
        rx_pause_quanta <= q;
        @(posedge clock);
        rx_pause_valid <= 1'b0;
    endtask

    task automatic t_regs;
        logic [7:0] a [4] = '{ADDR_REG_OFF, DATA_REG_OFF, FLOW_REG_OFF, 8'h20};
        logic [31:0] e [4] = '{32'h0000_5ac0, 32'h0, 32'h0050_0002, 32'h0};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            axi_rd(a[i], d, r);
            chk(d, e[i]);
            chk(r, (i == 3) ? RESP_SLVERR : RESP_OKAY);
        end
        axi_wr(8'h20, 32'hffff_ffff, 4'hf, r);
        chk(r, RESP_SLVERR);
    endtask

    task automatic t_mgmt_write;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(DATA_REG_OFF, 32'hffff_beef, 4'hf, r);
        axi_wr(ADDR_REG_OFF, 32'h0000_f803, 4'hf, r);
        axi_rd(ADDR_REG_OFF, d, r);
        chk(d, 32'h0000_f803);
        axi_wr(DATA_REG_OFF, 32'h0000_1111, 4'hf, r);
        wait_idle();
        chk(hdr, {ST_CODE, OP_WR, 5'h1f, 5'h00, TA_WR});
        chk(wdat, 16'hbeef);
        chk(ones, 6'h20);
        axi_rd(ADDR_REG_OFF, d, r);
        chk(d, 32'h0000_f802);
        axi_rd(DATA_REG_OFF, d, r);
        chk(d, 32'h0000_beef);
    endtask

    task automatic t_mgmt_read;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(ADDR_REG_OFF, 32'h0000_afc1, 4'hf, r);
        axi_wr(ADDR_REG_OFF, 32'h0000_0003, 4'hf, r);
        chk(r, RESP_OKAY);
        wait_idle();
        chk(hdr, {ST_CODE, OP_RD, 5'h15, 5'h1f, TA_WR});
        axi_rd(DATA_REG_OFF, d, r);
        chk(d, 32'h0000_5a1f);
        axi_rd(ADDR_REG_OFF, d, r);
        chk(d, 32'h0000_afc0);
    endtask

    task automatic t_pause_send;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(FLOW_REG_OFF, 32'h1234_0003, 4'hf, r);
        @(negedge clock);
        chk(pause_tx_req, 1'b1);
        chk(pause_tx_time, 16'h1234);
        axi_wr(FLOW_REG_OFF, 32'h5678_0000, 4'hc, r);
        axi_rd(FLOW_REG_OFF, d, r);
        chk(d, 32'h5678_0003);
        @(posedge clock);
        pause_tx_done <= 1'b1;
        @(posedge clock);
        pause_tx_done <= 1'b0;
        repeat (3) @(negedge clock);
        chk(pause_tx_req, 1'b0);
        axi_rd(FLOW_REG_OFF, d, r);
        chk(d, 32'h5678_0002);
    endtask

    task automatic t_pause_hold;
        logic [1:0] r;
        int n;
        n = 0;
        rx_pause(16'h0003);
        repeat (20) begin
            @(negedge clock);
            n += int'(tx_pause_hold);
        end
        chk(n, 32'd12);
        rx_pause(16'h0005);
        repeat (2) @(negedge clock);
        chk(tx_pause_hold, 1'b1);
        rx_pause(16'h0000);
        repeat (2) @(negedge clock);
        chk(tx_pause_hold, 1'b0);
        axi_wr(FLOW_REG_OFF, 32'h0, 4'h3, r);
        rx_pause(16'h0005);
        repeat (3) @(negedge clock);
        chk(tx_pause_hold, 1'b0);
        axi_wr(FLOW_REG_OFF, 32'h2, 4'h1, r);
        @(negedge clock);
        chk(tx_pause_hold, 1'b0);
    endtask

    initial begin
        rstn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {pause_tx_done, rx_pause_valid, rx_pause_quanta} = '0;
        repeat (5) @(posedge mdc_clk);
        @(posedge clock);
        rstn <= 1'b1;
        t_regs();
        t_mgmt_write();
        t_mgmt_read();
        t_pause_send();
        t_pause_hold();
        end_of_test();
    end

    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
endmodule
